// ==== inc/rso_pkg.sv ====
package rso_pkg;

  // Register offsets on the serial port.
  localparam logic [4:0] ADDR_RF_CHANNEL = 5'h05;
  localparam logic [4:0] ADDR_RF_SETUP   = 5'h06;
  localparam logic [4:0] ADDR_STATUS     = 5'h07;
  localparam logic [4:0] ADDR_OBSERVE    = 5'h08;
  localparam logic [4:0] ADDR_CARRIER    = 5'h09;

  // Command byte: upper three bits select read or write, lower five the register.
  localparam logic [2:0] CMD_READ  = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;

  // Status register field positions.
  localparam int STAT_RX_READY  = 6;
  localparam int STAT_TX_DONE   = 5;
  localparam int STAT_RETRY_LIM = 4;
  localparam int STAT_PIPE_LSB  = 1;
  localparam int STAT_TX_FULL   = 0;

  // Setup register field positions.
  localparam int SETUP_PWR_LSB = 1;
  localparam int SETUP_LNA     = 0;

  // Reset values.
  localparam logic [6:0] RST_RF_CHANNEL = 7'h02;
  localparam logic [4:0] RST_RF_SETUP   = 5'h0F;
  localparam logic [2:0] RST_PIPE       = 3'h7;
  localparam logic [2:0] PIPE_EMPTY     = 3'h7;

  // Output power in dBm, two's complement, for codes 00..11.
  localparam logic signed [7:0] PWR_M18 = 8'hEE;
  localparam logic signed [7:0] PWR_M12 = 8'hF4;
  localparam logic signed [7:0] PWR_M6  = 8'hFA;
  localparam logic signed [7:0] PWR_0   = 8'h00;

  // One-cycle event strobes from the radio core.
  typedef struct packed {
    logic rx_payload_stored;
    logic tx_sent;
    logic ack_received;
    logic retry_limit_hit;
    logic packet_lost;
    logic retransmit;
    logic new_packet_start;
  } rso_evt_t;

  // Level state of the data FIFOs.
  typedef struct packed {
    logic       rx_empty;
    logic [2:0] rx_head_pipe;
    logic       tx_full;
  } rso_fifo_t;

endpackage

// ==== rtl/rso_spi_shift.sv ====
`timescale 1ns/10ps
module rso_spi_shift (
  input  wire logic       clk_sys_i,    // System clock
  input  wire logic       nrst_i,       // Async reset, active low
  input  wire logic       sck_i,        // Serial clock, sampled
  input  wire logic       csn_n_i,      // Chip select, active low
  input  wire logic       mosi_i,       // Serial data in
  input  wire logic [7:0] tx_byte_i,    // Next byte to shift out
  output logic            miso_o,       // Serial data out
  output logic            miso_oe_o,    // Drive enable for serial data out
  output logic            byte_valid_o, // Pulse: a byte was received
  output logic [7:0]      rx_byte_o,    // Received byte
  output logic            first_byte_o  // High until the first byte of a frame ends
);

  logic       sck_q;
  logic       csn_q;
  logic [2:0] bit_q;
  logic [7:0] rx_sr_q;
  logic [7:0] tx_sr_q;
  logic       load_q;
  logic       rise;
  logic       fall;

  assign rise   = !csn_n_i && !sck_q && sck_i;
  assign fall   = !csn_n_i && sck_q && !sck_i;
  assign miso_o = tx_sr_q[7];

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_q     <= 1'b0;
      csn_q     <= 1'b1;
      miso_oe_o <= 1'b0;
    end else begin
      sck_q     <= sck_i;
      csn_q     <= csn_n_i;
      miso_oe_o <= !csn_n_i;
    end
  end

  // Receive side: sample on the rising serial clock edge, MSB first.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_q        <= 3'h0;
      rx_sr_q      <= 8'h00;
      rx_byte_o    <= 8'h00;
      byte_valid_o <= 1'b0;
      first_byte_o <= 1'b1;
    end else begin
      byte_valid_o <= 1'b0;
      // The first-byte mark drops only after the valid pulse, so the pulse
      // of the command byte still sees it high.
      if (byte_valid_o) begin
        first_byte_o <= 1'b0;
      end
      if (csn_n_i) begin
        bit_q        <= 3'h0;
        first_byte_o <= 1'b1;
      end else if (rise) begin
        rx_sr_q <= {rx_sr_q[6:0], mosi_i};
        bit_q   <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          rx_byte_o    <= {rx_sr_q[6:0], mosi_i};
          byte_valid_o <= 1'b1;
        end
      end
    end
  end

  // Transmit side: the status byte is loaded as select falls, so the first
  // bit is ready before the first rising edge; later bytes load on the
  // falling edge that ends a byte.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_sr_q <= 8'h00;
      load_q  <= 1'b0;
    end else if (csn_q && !csn_n_i) begin
      tx_sr_q <= tx_byte_i;
      load_q  <= 1'b0;
    end else if (rise && bit_q == 3'h7) begin
      load_q <= 1'b1;
    end else if (fall) begin
      tx_sr_q <= load_q ? tx_byte_i : {tx_sr_q[6:0], 1'b0};
      load_q  <= 1'b0;
    end
  end

endmodule

// ==== rtl/rso_status_regs.sv ====
`timescale 1ns/10ps
// Function
// - Power code selects -18/-12/-6/0 dBm
// - Status byte shifts out during command byte
// - Set receive-ready flag on new payload
// - Set done flag on send, or on ack instead when auto ack is enabled
// - Write one clears flag, zero keeps
// - Retry-limit flag halts communication until cleared
// - Pipe field shows head pipe, 111 empty
// - Bit 0 shows transmit FIFO full
// - Lost-packet count saturates at fifteen
// - Any channel write clears lost count
// - Retransmit count restarts on new packet
// - Carrier register upper bits read zero
module rso_status_regs (
  input  wire logic             clk_sys_i,       // System clock, 125 MHz
  input  wire logic             nrst_i,          // Async reset, active low
  input  wire logic             spi_sck_i,       // Serial clock from host
  input  wire logic             spi_csn_n_i,     // Chip select from host, active low
  input  wire logic             spi_mosi_i,      // Serial data from host
  output logic                  spi_miso_o,      // Serial data to host
  output logic                  spi_miso_oe_o,   // Drive enable for serial data out
  input  wire rso_pkg::rso_evt_t  evt_i,         // Event strobes from radio core
  input  wire rso_pkg::rso_fifo_t fifo_i,        // FIFO state from radio core
  input  wire logic             auto_ack_en_i,   // Automatic acknowledgement enabled
  input  wire logic             carrier_detect_i,// Carrier present
  output logic [6:0]            rf_channel_o,    // Channel setting
  output logic [1:0]            tx_power_select_o, // Power code
  output logic signed [7:0]     tx_power_dbm_o,  // Output power in dBm
  output logic                  low_noise_amp_gain_o, // Receiver gain setting
  output logic                  comm_enable_o,   // Radio may communicate
  output logic                  rx_data_ready_flag_o, // Sticky flag copy
  output logic                  tx_done_flag_o,  // Sticky flag copy
  output logic                  retry_limit_flag_o // Sticky flag copy
);

  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       first_byte;
  logic [7:0] tx_byte;
  logic [7:0] cmd_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_mux;
  logic [7:0] status_byte;
  logic [4:0] rf_setup_q;
  logic [2:0] pipe_q;
  logic       tx_full_q;
  logic [3:0] lost_cnt_q;
  logic [3:0] retx_cnt_q;
  logic       wr_stb;
  logic       wr_status;
  logic       wr_channel;
  logic       set_rx;
  logic       set_done;

  rso_spi_shift u_shift (
    .clk_sys_i    (clk_sys_i),
    .nrst_i       (nrst_i),
    .sck_i        (spi_sck_i),
    .csn_n_i      (spi_csn_n_i),
    .mosi_i       (spi_mosi_i),
    .tx_byte_i    (tx_byte),
    .miso_o       (spi_miso_o),
    .miso_oe_o    (spi_miso_oe_o),
    .byte_valid_o (byte_valid),
    .rx_byte_o    (rx_byte),
    .first_byte_o (first_byte)
  );

  assign status_byte = {1'b0, rx_data_ready_flag_o, tx_done_flag_o, retry_limit_flag_o,
                        pipe_q, tx_full_q};
  assign tx_byte     = first_byte ? status_byte : rd_data_q;

  assign wr_stb     = byte_valid && !first_byte && cmd_q[7:5] == rso_pkg::CMD_WRITE;
  assign wr_status  = wr_stb && cmd_q[4:0] == rso_pkg::ADDR_STATUS;
  assign wr_channel = wr_stb && cmd_q[4:0] == rso_pkg::ADDR_RF_CHANNEL;

  // Read data is chosen from the freshly received command byte.
  always_comb begin
    case (rx_byte[4:0])
      rso_pkg::ADDR_RF_CHANNEL: rd_mux = {1'b0, rf_channel_o};
      rso_pkg::ADDR_RF_SETUP:   rd_mux = {3'h0, rf_setup_q};
      rso_pkg::ADDR_STATUS:     rd_mux = status_byte;
      rso_pkg::ADDR_OBSERVE:    rd_mux = {lost_cnt_q, retx_cnt_q};
      rso_pkg::ADDR_CARRIER:    rd_mux = {7'h00, carrier_detect_i};
      default:                  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_q     <= 8'h00;
      rd_data_q <= 8'h00;
    end else if (byte_valid && first_byte) begin
      cmd_q     <= rx_byte;
      rd_data_q <= rd_mux;
    end
  end

  // Writes to the observation and carrier registers, and to status bits
  // 3:0, have no decode at all and so cannot alter them.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_channel_o <= rso_pkg::RST_RF_CHANNEL;
      rf_setup_q   <= rso_pkg::RST_RF_SETUP;
    end else if (wr_channel) begin
      rf_channel_o <= rx_byte[6:0];
    end else if (wr_stb && cmd_q[4:0] == rso_pkg::ADDR_RF_SETUP) begin
      rf_setup_q <= rx_byte[4:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_power_select_o    <= 2'h3;
      tx_power_dbm_o       <= rso_pkg::PWR_0;
      low_noise_amp_gain_o <= 1'b1;
    end else begin
      tx_power_select_o    <= rf_setup_q[rso_pkg::SETUP_PWR_LSB +: 2];
      low_noise_amp_gain_o <= rf_setup_q[rso_pkg::SETUP_LNA];
      case (rf_setup_q[rso_pkg::SETUP_PWR_LSB +: 2])
        2'h0:    tx_power_dbm_o <= rso_pkg::PWR_M18;
        2'h1:    tx_power_dbm_o <= rso_pkg::PWR_M12;
        2'h2:    tx_power_dbm_o <= rso_pkg::PWR_M6;
        default: tx_power_dbm_o <= rso_pkg::PWR_0;
      endcase
    end
  end

  // Interrupt flags: a hardware set in the same cycle as a clear wins, so
  // no event is lost.
  assign set_rx   = evt_i.rx_payload_stored;
  assign set_done = auto_ack_en_i ? evt_i.ack_received : evt_i.tx_sent;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_data_ready_flag_o <= 1'b0;
      tx_done_flag_o       <= 1'b0;
      retry_limit_flag_o   <= 1'b0;
    end else begin
      if (set_rx) begin
        rx_data_ready_flag_o <= 1'b1;
      end else if (wr_status && rx_byte[rso_pkg::STAT_RX_READY]) begin
        rx_data_ready_flag_o <= 1'b0;
      end
      if (set_done) begin
        tx_done_flag_o <= 1'b1;
      end else if (wr_status && rx_byte[rso_pkg::STAT_TX_DONE]) begin
        tx_done_flag_o <= 1'b0;
      end
      if (evt_i.retry_limit_hit) begin
        retry_limit_flag_o <= 1'b1;
      end else if (wr_status && rx_byte[rso_pkg::STAT_RETRY_LIM]) begin
        retry_limit_flag_o <= 1'b0;
      end
    end
  end

  // The radio core must hold off while the retry-limit flag stands.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      comm_enable_o <= 1'b1;
    end else begin
      comm_enable_o <= !retry_limit_flag_o && !evt_i.retry_limit_hit;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pipe_q    <= rso_pkg::RST_PIPE;
      tx_full_q <= 1'b0;
    end else begin
      pipe_q    <= fifo_i.rx_empty ? rso_pkg::PIPE_EMPTY : fifo_i.rx_head_pipe;
      tx_full_q <= fifo_i.tx_full;
    end
  end

  // A channel write clears the lost count even if the value is unchanged,
  // so a dummy write is the host's way to restart loss statistics.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lost_cnt_q <= 4'h0;
    end else if (wr_channel) begin
      lost_cnt_q <= 4'h0;
    end else if (evt_i.packet_lost && lost_cnt_q != 4'hF) begin
      lost_cnt_q <= lost_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      retx_cnt_q <= 4'h0;
    end else if (evt_i.new_packet_start) begin
      retx_cnt_q <= 4'h0;
    end else if (evt_i.retransmit && retx_cnt_q != 4'hF) begin
      retx_cnt_q <= retx_cnt_q + 4'h1;
    end
  end

endmodule

// ==== test/rso_status_regs_properties.sv ====
`timescale 1ns/10ps
module rso_status_regs_props (
  input wire logic              clk_sys_i,            // Clock
  input wire logic              nrst_i,               // Reset
  input wire logic              spi_csn_n_i,          // Select
  input wire logic              spi_miso_o,           // Data out
  input wire logic              spi_miso_oe_o,        // Enable
  input wire rso_pkg::rso_evt_t evt_i,                // Events
  input wire logic              auto_ack_en_i,        // Ack mode
  input wire logic [1:0]        tx_power_select_o,    // Code
  input wire logic signed [7:0] tx_power_dbm_o,       // Power
  input wire logic              comm_enable_o,        // Enable
  input wire logic              rx_data_ready_flag_o, // Flag
  input wire logic              tx_done_flag_o,       // Flag
  input wire logic              retry_limit_flag_o    // Flag
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  function automatic logic [7:0] to_dbm(input logic [1:0] c);
    return c[1] ? (c[0] ? 8'h00 : 8'hFA) : (c[0] ? 8'hF4 : 8'hEE);
  endfunction
  // The host may not clock before two cycles of select, so bit 7 is still out.
  sequence sel_s;
    $fell(spi_csn_n_i) ##1 !spi_csn_n_i [*2];
  endsequence
  frame_start_a:
    assert property (sel_s |-> spi_miso_oe_o && !spi_miso_o) else $error("no status at select");
  oe_track_a:
    assert property ($stable(spi_csn_n_i) [*3] |-> spi_miso_oe_o != spi_csn_n_i)
    else $error("miso enable wrong");
  rx_set_a:
    assert property (evt_i.rx_payload_stored |=> rx_data_ready_flag_o) else $error("rx flag");
  done_set_a:
    assert property ((auto_ack_en_i ? evt_i.ack_received : evt_i.tx_sent) |=> tx_done_flag_o)
    else $error("done flag not set");
  done_cause_a:
    assert property ($rose(tx_done_flag_o) |-> $past(evt_i.ack_received)
      || ($past(evt_i.tx_sent) && !$past(auto_ack_en_i))) else $error("done flag cause");
  halt_next_a:
    assert property (evt_i.retry_limit_hit |=> retry_limit_flag_o && !comm_enable_o)
    else $error("no halt");
  halt_hold_a:
    assert property (retry_limit_flag_o |-> !comm_enable_o) else $error("halt not held");
  clear_frame_a:
    assert property ($fell(rx_data_ready_flag_o) || $fell(tx_done_flag_o)
      || $fell(retry_limit_flag_o) |-> !$past(spi_csn_n_i)) else $error("flag lost");
  power_map_a:
    assert property (tx_power_select_o == $past(tx_power_select_o)
      |-> tx_power_dbm_o == to_dbm(tx_power_select_o)) else $error("power map");
endmodule
bind rso_status_regs rso_status_regs_props u_props (.clk_sys_i, .nrst_i, .spi_csn_n_i,
  .spi_miso_o, .spi_miso_oe_o, .evt_i, .auto_ack_en_i, .tx_power_select_o, .tx_power_dbm_o,
  .comm_enable_o, .rx_data_ready_flag_o, .tx_done_flag_o, .retry_limit_flag_o);

// ==== test/rso_host_model.sv ====
`timescale 1ns/10ps
module rso_host_model (
  input  wire logic clk_sys_i, // Clock
  input  wire logic miso_i,    // Data in
  output logic      sck_o,     // Clock out
  output logic      csn_n_o,   // Select
  output logic      mosi_o     // Data out
);
  int half = 3;
  initial begin
    sck_o = 1'b0;
    csn_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Two-byte mode 0 frame; data moves only while the clock is low.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      output logic [7:0] st, output logic [7:0] rd);
    logic [15:0] w;
    logic [15:0] r;
    w = {cmd, dat};
    @(posedge clk_sys_i) #1 csn_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = w[i];
      repeat (half) @(posedge clk_sys_i);
      r[i] = miso_i;
      #1 sck_o = 1'b1;
      repeat (half) @(posedge clk_sys_i);
      #1 sck_o = 1'b0;
    end
    repeat (half) @(posedge clk_sys_i);
    #1 csn_n_o = 1'b1;
    // A released line must not keep showing its last bit.
    mosi_o = ~mosi_o;
    {st, rd} = r;
    repeat (2) @(posedge clk_sys_i);
  endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic               clk_sys_i = 1'b0;
  logic               nrst_i = 1'b0;
  logic               sck, csn_n, mosi, miso, miso_oe, miso_w, comm_en;
  logic               ack_en = 1'b0;
  logic               cd = 1'b1;
  logic signed [7:0]  dbm;
  logic [6:0]         chan;
  logic               lna;
  rso_pkg::rso_evt_t  evt = '0;
  rso_pkg::rso_fifo_t fifo = 5'h10;
  logic [7:0]         st, rd;
  logic [2:0]         eflags = '0;
  int                 num_errors = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  // The data-out line is pulled high while the device leaves it.
  assign miso_w = miso_oe ? miso : 1'b1;
  rso_status_regs dut (.clk_sys_i, .nrst_i, .spi_sck_i(sck), .spi_csn_n_i(csn_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .evt_i(evt), .fifo_i(fifo),
    .auto_ack_en_i(ack_en), .carrier_detect_i(cd), .rf_channel_o(chan), .tx_power_select_o(),
    .tx_power_dbm_o(dbm), .low_noise_amp_gain_o(lna), .comm_enable_o(comm_en),
    .rx_data_ready_flag_o(), .tx_done_flag_o(), .retry_limit_flag_o());
  rso_host_model host (.clk_sys_i, .miso_i(miso_w), .sck_o(sck), .csn_n_o(csn_n), .mosi_o(mosi));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ev(input rso_pkg::rso_evt_t e);
    @(posedge clk_sys_i) #1 evt = e;
    @(posedge clk_sys_i) #1 evt = '0;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    host.xfer({rso_pkg::CMD_READ, a}, 8'h00, st, rd);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    host.xfer({rso_pkg::CMD_WRITE, a}, d, st, rd);
  endtask
  function automatic logic [7:0] stat_exp(input logic [2:0] p, input logic f);
    return {1'b0, eflags, p, f};
  endfunction
  function automatic logic [7:0] dbm_exp(input logic [1:0] c);
    return c == 2'h0 ? 8'hEE : c == 2'h1 ? 8'hF4 : c == 2'h2 ? 8'hFA : 8'h00;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    int n;
    n = $urandom(68);
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    rd_reg(rso_pkg::ADDR_STATUS);
    chk(st, stat_exp(rso_pkg::PIPE_EMPTY, 1'b0), "status shifted");
    rd_reg(rso_pkg::ADDR_CARRIER);
    chk(rd, 8'h01, "carrier reg");
    wr_reg(rso_pkg::ADDR_OBSERVE, 8'hFF);
    wr_reg(rso_pkg::ADDR_CARRIER, 8'hFE);
    rd_reg(rso_pkg::ADDR_OBSERVE);
    chk(rd, 8'h00, "observe kept");
    $display("test reset done");
    for (int p = 0; p < 7; p++) begin
      #1 fifo = {p == 6, p[2:0], 1'($urandom)};
      wr_reg(rso_pkg::ADDR_STATUS, 8'h8F);
      rd_reg(rso_pkg::ADDR_STATUS);
      chk(rd, stat_exp(p == 6 ? rso_pkg::PIPE_EMPTY : p[2:0], fifo.tx_full), "pipe");
    end
    #1 fifo = 5'h10;
    $display("test fifo fields done");
    #1 ack_en = 1'b1;
    ev(7'h20);
    ev(7'h40);
    eflags = 3'b100;
    rd_reg(rso_pkg::ADDR_STATUS);
    chk(st, stat_exp(3'h7, 1'b0), "done waits for ack");
    ev(7'h10);
    ev(7'h08);
    eflags = 3'b111;
    chk({7'h0, comm_en}, 8'h00, "halted");
    rd_reg(rso_pkg::ADDR_STATUS);
    chk(st, stat_exp(3'h7, 1'b0), "all flags");
    wr_reg(rso_pkg::ADDR_STATUS, 8'h10);
    eflags = 3'b110;
    chk({7'h0, comm_en}, 8'h01, "resumed");
    rd_reg(rso_pkg::ADDR_STATUS);
    chk(st, stat_exp(3'h7, 1'b0), "zero keeps");
    wr_reg(rso_pkg::ADDR_STATUS, 8'h60);
    eflags = 3'b000;
    rd_reg(rso_pkg::ADDR_STATUS);
    chk(st, stat_exp(3'h7, 1'b0), "one clears");
    $display("test flags done");
    host.half = 4 + $urandom_range(4);
    n = 16 + $urandom_range(4);
    repeat (n) ev(7'h04);
    rd_reg(rso_pkg::ADDR_OBSERVE);
    chk(rd, 8'hF0, "lost saturates");
    wr_reg(rso_pkg::ADDR_RF_CHANNEL, 8'h02);
    rd_reg(rso_pkg::ADDR_OBSERVE);
    chk(rd, 8'h00, "same channel clears");
    n = $urandom_range(14, 1);
    repeat (n) ev(7'h02);
    rd_reg(rso_pkg::ADDR_OBSERVE);
    chk(rd, 8'(n), "retransmits");
    ev(7'h01);
    rd_reg(rso_pkg::ADDR_OBSERVE);
    chk(rd, 8'h00, "new packet");
    $display("test counters done");
    host.half = 3;
    for (int c = 0; c < 4; c++) begin
      wr_reg(rso_pkg::ADDR_RF_SETUP, {5'h01, c[1:0], c[0]});
      chk(dbm, dbm_exp(c[1:0]), "power");
      chk({7'h00, lna}, {7'h00, c[0]}, "gain bit");
    end
    wr_reg(rso_pkg::ADDR_RF_CHANNEL, 8'hC5);
    chk({1'b0, chan}, 8'h45, "channel");
    $display("test power done");
    print_verdict;
  end
endmodule
